//--- hw/qrs_top.v
// Overview of operation
// - Quad read: quad address, four dummies, data
// - Quad read opcodes accepted only with enable set
// - Low mode nibble is ignored
// - Skip field 10 omits next opcode
// - Other skip values need full opcode
// - Mode reset clears stored mode byte
// - Mode reset is FF or FFFF
// - Wrap setting governs following quad reads
// - Wrap setting governs following word reads
// - Wrap confines data to aligned section
// - Wrap starts at address, loops section
// - Disable bit and length field control wrap
// - Wrap off at reset; 8 to 64
// - Word read: even address, two dummies
// - Word read may skip its opcode
// - Octal read has no dummy clocks
// - Octal read may skip its opcode
`timescale 1ns/100ps
`include "qrs_map.vh"
module qrs_top (
  input wire mclk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire spi_cs_n_i,
  input wire spi_sclk_i,
  input wire [3:0] data_line_i,
  output wire [3:0] data_line_o,
  output wire [3:0] data_line_oe_o,
  output wire [23:0] mem_addr_o,
  input wire [7:0] mem_rdata_i
);
  // Sequencer states. IGN swallows the rest of a refused or finished command.
  localparam ST_IDLE = 3'h0;
  localparam ST_OPC = 3'h1;
  localparam ST_ADDR = 3'h2;
  localparam ST_MODE = 3'h3;
  localparam ST_DUMMY = 3'h4;
  localparam ST_DATA = 3'h5;
  localparam ST_WRAP = 3'h6;
  localparam ST_IGN = 3'h7;

  // Reset release and synchronised pins.
  reg rst_m_q;
  reg rst_s_q;
  wire rst_n;
  wire [5:0] pins_s;
  wire cs_s;
  wire sclk_s;
  wire [3:0] io_s;

  // Link edge detection.
  reg cs_p_q;
  reg sclk_p_q;
  wire rise;
  wire fall;
  wire cs_fall;
  wire cs_rise;
  wire four_line_enable;
  wire cont_on;

  // Sequencer state, counters and shift registers.
  reg [2:0] st_q;
  reg [4:0] cnt_q;
  reg [7:0] sh_q;
  reg [23:0] addr_q;
  reg [1:0] kind_q;
  reg [7:0] mode_q;
  reg [2:0] wrap_q;
  reg [7:0] byte_q;
  reg nib_lo_q;
  reg ones_q;
  reg [4:0] edges_q;

  // Registered link and memory outputs.
  reg [3:0] dout_q;
  reg [3:0] doe_q;
  reg [23:0] mem_addr_q;

  // Combinational decode helpers.
  wire [7:0] opc;
  wire [23:0] addr_full;
  wire [31:0] stat;

  // Reset is released through two flops; assertion stays asynchronous.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  assign rst_n = rst_s_q;

  // Every link pin crosses into the system clock here.
  qrs_sync #(
    .W(6)
  ) u_sync (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .d_i({spi_cs_n_i, spi_sclk_i, data_line_i}),
    .q_o(pins_s)
  );
  // Split the synchronised group back into named pins.
  assign cs_s = pins_s[5];
  assign sclk_s = pins_s[4];
  assign io_s = pins_s[3:0];

  // Register slave; it holds the four-line enable.
  qrs_apb u_apb (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .stat_i(stat),
    .addr_i(addr_q),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .four_line_enable_o(four_line_enable)
  );

  // Status word: mode byte, wrap field, state, continuous flag.
  // Bits 31..16 read as zero and bit 11 is spare.
  assign stat = {16'h0000, cont_on, st_q, 1'b0, wrap_q, mode_q};

  // Dummy clocks that each read kind needs before data.
  function [4:0] dummy_len;
    input [1:0] k;
    begin
      case (k)
        `QRS_KIND_QUAD: dummy_len = `QRS_DUMMY_QUAD;
        `QRS_KIND_WORD: dummy_len = `QRS_DUMMY_WORD;
        default: dummy_len = `QRS_DUMMY_OCT;
      endcase
    end
  endfunction

  // Next byte address, looping inside the wrap section when enabled.
  function [23:0] next_addr;
    input [23:0] a;
    input [2:0] w;
    input [1:0] k;
    reg [5:0] m;
    reg [5:0] inc;
    begin
      case (w[`QRS_WRAP_LEN_HI:`QRS_WRAP_LEN_LO])
        2'h0: m = 6'h07;
        2'h1: m = 6'h0F;
        2'h2: m = 6'h1F;
        default: m = 6'h3F;
      endcase
      inc = a[5:0] + 6'h01;
      // Octal reads ignore wrap; only quad and word reads use it.
      if (!w[`QRS_WRAP_DIS] && k != `QRS_KIND_OCT) begin
        next_addr = {a[23:6], (a[5:0] & ~m) | (inc & m)};
      end else begin
        next_addr = a + 24'h000001;
      end
    end
  endfunction

  // Edge finders read the second sync stage and its delayed copy.
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cs_p_q <= 1'b1;
      sclk_p_q <= 1'b1; // Matches the synchroniser's reset level.
    end else begin
      cs_p_q <= cs_s;
      sclk_p_q <= sclk_s;
    end
  end
  // Edges only count while selected, so a clock idling between frames is harmless.
  assign rise = sclk_s & ~sclk_p_q & ~cs_s;
  assign fall = ~sclk_s & sclk_p_q & ~cs_s;
  assign cs_fall = ~cs_s & cs_p_q;
  assign cs_rise = cs_s & ~cs_p_q;

  // Continuous mode is live while the stored skip field holds binary 10.
  assign cont_on = (mode_q[`QRS_SKIP_HI:`QRS_SKIP_LO] == `QRS_SKIP_ON);
  // Opcode shift with the newest bit from data line 0.
  assign opc = {sh_q[6:0], io_s[0]};
  // Address as the last nibble lands; alignment forced per kind.
  assign addr_full = (kind_q == `QRS_KIND_OCT) ?
                     {addr_q[19:0], 4'h0} :
                     (kind_q == `QRS_KIND_WORD) ?
                     {addr_q[19:0], io_s[3:1], 1'b0} :
                     {addr_q[19:0], io_s};

  // Main sequencer. Line outputs change on falling link clock edges while selected,
  // which leaves the host half a link period to sample them.
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 5'h00;
      sh_q <= 8'h00;
      addr_q <= 24'h000000;
      kind_q <= `QRS_KIND_QUAD;
      mode_q <= `QRS_MODE_RST;
      wrap_q <= `QRS_WRAP_RST;
      byte_q <= 8'h00;
      nib_lo_q <= 1'b0;
      ones_q <= 1'b1;
      edges_q <= 5'h00;
      dout_q <= 4'h0;
      doe_q <= 4'h0;
      mem_addr_q <= 24'h000000;
    end else if (cs_s) begin
      // Deselect ends every command and frees the lines.
      st_q <= ST_IDLE;
      doe_q <= 4'h0;
      // An all-ones frame of 8 or 16 clocks drops continuous mode.
      // The 16-clock form is taken too, so a host that always sends the long
      // form is never left stuck in quad continuous mode.
      if (cs_rise && ones_q &&
          (edges_q == `QRS_MRST_QUAD || edges_q == `QRS_MRST_DUAL)) begin
        mode_q <= `QRS_MODE_RST;
      end
    end else begin
      // A new selection restarts the frame counters.
      if (cs_fall) begin
        cnt_q <= 5'h00;
        ones_q <= 1'b1;
        edges_q <= 5'h00;
        nib_lo_q <= 1'b0;
        // Stored skip field decides whether an opcode comes first.
        if (cont_on) begin
          st_q <= ST_ADDR;
        end else begin
          st_q <= ST_OPC;
        end
      end
      // Every command bit is taken on a rising link clock edge.
      if (rise) begin
        cnt_q <= cnt_q + 5'h01;
        if (edges_q != 5'h1F) begin
          edges_q <= edges_q + 5'h01;
        end
        ones_q <= ones_q & io_s[0];
        case (st_q)
          ST_OPC: begin
            // Opcode arrives one bit per clock on line 0.
            sh_q <= opc;
            if (cnt_q == `QRS_OPC_LAST) begin
              cnt_q <= 5'h00;
              if (opc == `QRS_OP_QUAD && four_line_enable) begin
                kind_q <= `QRS_KIND_QUAD;
                st_q <= ST_ADDR;
              end else if (opc == `QRS_OP_WORD && four_line_enable) begin
                kind_q <= `QRS_KIND_WORD;
                st_q <= ST_ADDR;
              end else if (opc == `QRS_OP_OCT && four_line_enable) begin
                kind_q <= `QRS_KIND_OCT;
                st_q <= ST_ADDR;
              end else if (opc == `QRS_OP_WRAP) begin
                st_q <= ST_WRAP;
              end else begin
                // Refused or unknown opcodes idle until deselect; lines stay released.
                st_q <= ST_IGN;
              end
            end
          end
          ST_ADDR: begin
            // Address arrives a nibble per clock, high first.
            addr_q <= {addr_q[19:0], io_s};
            if (cnt_q == `QRS_ADDR_LAST) begin
              cnt_q <= 5'h00;
              addr_q <= addr_full;
              mem_addr_q <= addr_full;
              st_q <= ST_MODE;
            end
          end
          ST_MODE: begin
            sh_q <= {sh_q[3:0], io_s};
            if (cnt_q == `QRS_MODE_LAST) begin
              cnt_q <= 5'h00;
              // Low nibble is dropped; only the high one matters.
              mode_q <= {sh_q[3:0], 4'h0};
              if (dummy_len(kind_q) == 5'h00) begin
                st_q <= ST_DATA;
              end else begin
                st_q <= ST_DUMMY;
              end
            end
          end
          ST_DUMMY: begin
            // Line values during dummies are not looked at.
            if (cnt_q == dummy_len(kind_q) - 5'h01) begin
              cnt_q <= 5'h00;
              st_q <= ST_DATA;
            end
          end
          ST_WRAP: begin
            // Six dummy nibbles, then wrap bits 7..4, then 3..0.
            if (cnt_q == `QRS_WRAP_FIELD) begin
              wrap_q <= io_s[2:0];
              st_q <= ST_IGN;
            end
          end
          default: begin
            cnt_q <= cnt_q;
          end
        endcase
      end
      // Host has released the lines by now, so driving is safe.
      // The byte is latched with its high nibble, and the address steps after
      // the low nibble, which leaves memory a full link period to answer.
      if (fall && st_q == ST_DATA) begin
        doe_q <= 4'hF;
        nib_lo_q <= ~nib_lo_q;
        if (!nib_lo_q) begin
          dout_q <= mem_rdata_i[7:4];
          byte_q <= mem_rdata_i;
        end else begin
          dout_q <= byte_q[3:0];
          addr_q <= next_addr(addr_q, wrap_q, kind_q);
          mem_addr_q <= next_addr(addr_q, wrap_q, kind_q);
        end
      end
    end
  end

  // Outputs come straight from their registers.
  assign data_line_o = dout_q;
  assign data_line_oe_o = doe_q;
  assign mem_addr_o = mem_addr_q;
endmodule

//--- hw/qrs_map.vh
`ifndef QRS_MAP_VH
`define QRS_MAP_VH
// Instruction codes seen on data line 0.
`define QRS_OP_QUAD 8'hEB
`define QRS_OP_WORD 8'hE7
`define QRS_OP_OCT 8'hE3
`define QRS_OP_WRAP 8'h77
`define QRS_OP_MRST 8'hFF
// Read kinds kept for continuous mode.
`define QRS_KIND_QUAD 2'h0
`define QRS_KIND_WORD 2'h1
`define QRS_KIND_OCT 2'h2
// Dummy clocks per read kind.
`define QRS_DUMMY_QUAD 5'h04
`define QRS_DUMMY_WORD 5'h02
`define QRS_DUMMY_OCT 5'h00
// Last clock count of each phase, and mode reset frame lengths in clocks.
`define QRS_OPC_LAST 5'h07
`define QRS_ADDR_LAST 5'h05
`define QRS_MODE_LAST 5'h01
`define QRS_WRAP_FIELD 5'h06
`define QRS_MRST_QUAD 5'h08
`define QRS_MRST_DUAL 5'h10
// Continuous mode byte: skip field and its magic value.
`define QRS_SKIP_HI 5
`define QRS_SKIP_LO 4
`define QRS_SKIP_ON 2'h2
`define QRS_MODE_RST 8'h00
// Wrap control field: bit 0 disables, bits 2..1 select length.
`define QRS_WRAP_DIS 0
`define QRS_WRAP_LEN_HI 2
`define QRS_WRAP_LEN_LO 1
`define QRS_WRAP_RST 3'h1
// Register offsets (byte addresses).
`define QRS_REG_CTRL 12'h000
`define QRS_REG_STAT 12'h004
`define QRS_REG_ADDR 12'h008
// Control register fields.
`define QRS_CTRL_ENA 0
`define QRS_CTRL_RST 32'h00000000
`endif

//--- hw/qrs_sync.v
`timescale 1ns/100ps
// Two-flop synchroniser for a group of pin levels.
module qrs_sync #(
  parameter W = 6
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // The first stage feeds only the second one.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

//--- hw/qrs_apb.v
`timescale 1ns/100ps
`include "qrs_map.vh"
// APB slave with one wait-free access phase.
module qrs_apb (
  input wire clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] stat_i,
  input wire [23:0] addr_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  output wire four_line_enable_o
);
  reg [31:0] ctrl_q;
  wire setup;
  wire hit;

  assign setup = psel_i & ~penable_i;
  assign hit = (paddr_i == `QRS_REG_CTRL) | (paddr_i == `QRS_REG_STAT) |
               (paddr_i == `QRS_REG_ADDR);
  assign four_line_enable_o = ctrl_q[`QRS_CTRL_ENA];

  // Answer is prepared in setup so access always completes in one cycle.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `QRS_CTRL_RST;
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup & ~hit;
      // Read data stands for the access cycle only and is zero otherwise.
      prdata_o <= 32'h00000000;
      if (setup && !pwrite_i) begin
        case (paddr_i)
          `QRS_REG_CTRL: prdata_o <= ctrl_q;
          `QRS_REG_STAT: prdata_o <= stat_i;
          `QRS_REG_ADDR: prdata_o <= {8'h00, addr_i};
          default: prdata_o <= 32'h00000000;
        endcase
      end
      // Only the enable bit is writable; other bits read as zero.
      if (psel_i && penable_i && pready_o && pwrite_i &&
          paddr_i == `QRS_REG_CTRL) begin
        ctrl_q <= {31'h00000000, pwdata_i[`QRS_CTRL_ENA]};
      end
    end
  end
endmodule

//--- tb/qrs_properties.sv
`timescale 1ns/100ps
`include "qrs_map.vh"
// Watches the top pins; a copy of the enable bit follows register writes.
module qrs_properties (
  input wire mclk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire spi_cs_n_i,
  input wire spi_sclk_i,
  input wire [3:0] data_line_oe_o,
  input wire [23:0] mem_addr_o
);
  reg ena_q;
  wire acc = psel_i && penable_i && pready_o;
  wire hit = paddr_i == `QRS_REG_CTRL || paddr_i == `QRS_REG_STAT || paddr_i == `QRS_REG_ADDR;
  // Mirror of the enable bit, so refusal is judged without looking inside.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ena_q <= 1'b0;
    end else if (acc && pwrite_i && paddr_i == `QRS_REG_CTRL) begin
      ena_q <= pwdata_i[`QRS_CTRL_ENA];
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("No ready after setup.");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("Ready held too long.");
  a_err_unmapped: assert property (acc |-> pslverr_o == !hit)
    else $error("Error flag wrong for address.");
  a_err_no_data: assert property (acc && pslverr_o |-> prdata_o == 32'h0)
    else $error("Read data on error.");
  a_refuse_off: assert property (!ena_q |-> data_line_oe_o == 4'h0)
    else $error("Lines driven with enable off.");
  a_oe_all_lines: assert property (data_line_oe_o == 4'h0 || data_line_oe_o == 4'hF)
    else $error("Partial line drive.");
  a_oe_on_fall: assert property ($rose(data_line_oe_o[0]) |-> !spi_cs_n_i && !$past(spi_sclk_i, 2))
    else $error("Drive began off a falling clock.");
  a_oe_end_cs: assert property ($rose(spi_cs_n_i) |-> ##[1:8] data_line_oe_o == 4'h0)
    else $error("Lines still driven after deselect.");
  a_addr_step: assert property (data_line_oe_o == 4'hF && $changed(mem_addr_o) |->
    mem_addr_o == $past(mem_addr_o) + 24'h1 ||
    ((mem_addr_o >> 6) == ($past(mem_addr_o) >> 6) && mem_addr_o < $past(mem_addr_o)))
    else $error("Address step out of section.");
endmodule

//--- tb/qrs_host.sv
`timescale 1ns/100ps
// Host controller in mode 0; link clock stands low between frames.
module qrs_host (
  input wire mclk_i,
  input wire [3:0] io_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] io_o,
  output logic [3:0] oe_o
);
  logic [7:0] rx [0:15];
  logic [3:0] rd;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o = 4'h0;
    oe_o = 4'h0;
  end
  // One link clock of 8 cycles; read data is taken just before the next fall.
  task nib(input logic [3:0] v, input logic [3:0] en);
    sclk_o <= 1'b0;
    io_o <= v;
    oe_o <= en;
    repeat (4) @(posedge mclk_i);
    sclk_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rd = io_i;
  endtask
  task frame(input logic opc, input logic [7:0] op, input logic [23:0] a,
             input logic [7:0] m, input int na, input int dum, input int nb);
    int i;
    @(posedge mclk_i);
    cs_n_o <= 1'b0;
    repeat (2) @(posedge mclk_i);
    for (i = 7; i >= 0 && opc; i--) nib({3'h0, op[i]}, 4'h1);
    for (i = 0; i < na; i++) nib(i < 6 ? a[23 - 4 * i -: 4] : m[31 - 4 * i -: 4], 4'hF);
    // Lines are released for dummies and data, no later than the first data fall.
    for (i = 0; i < dum; i++) nib(4'h0, 4'h0);
    for (i = 0; i < nb; i++) begin
      nib(4'h0, 4'h0);
      rx[i][7:4] = rd;
      nib(4'h0, 4'h0);
      rx[i][3:0] = rd;
    end
    sclk_o <= 1'b0;
    oe_o <= 4'h0;
    repeat (4) @(posedge mclk_i);
    cs_n_o <= 1'b1;
    repeat (8) @(posedge mclk_i);
  endtask
endmodule

//--- tb/tb_qrs_top.sv
`timescale 1ns/100ps
`include "qrs_map.vh"
module tb_qrs_top;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [7:0] mem_rdata_i = 8'h00;
  logic [3:0] tgl = 4'h5;
  wire [31:0] prdata_o;
  wire pready_o;
  wire pslverr_o;
  wire cs_n;
  wire sclk;
  wire [3:0] h_o;
  wire [3:0] h_oe;
  wire [3:0] d_o;
  wire [3:0] d_oe;
  wire [3:0] io;
  wire [23:0] mem_addr_o;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  int oe_cnt = 0;
  int k;
  logic [31:0] r;
  logic e;
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  always #10 mclk_i = ~mclk_i;
  // A line nobody drives flips every cycle, so a stale value cannot pass.
  assign io = (d_oe & d_o) | (~d_oe & h_oe & h_o) | (~d_oe & ~h_oe & tgl);
  // Memory answers a cycle after each address; the cycle count cuts a hang.
  always @(posedge mclk_i) begin
    tgl <= ~tgl;
    mem_rdata_i <= mem(mem_addr_o);
    cyc <= cyc + 1;
    if (d_oe !== 4'h0) oe_cnt <= oe_cnt + 1;
    if (cyc == 40000) begin
      num_errors++;
      finish_test;
    end
  end
  qrs_top qrs_top_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .spi_cs_n_i(cs_n),
    .spi_sclk_i(sclk), .data_line_i(io), .data_line_o(d_o), .data_line_oe_o(d_oe),
    .mem_addr_o(mem_addr_o), .mem_rdata_i(mem_rdata_i));
  qrs_host qrs_host_i (.mclk_i(mclk_i), .io_i(io), .cs_n_o(cs_n), .sclk_o(sclk),
    .io_o(h_o), .oe_o(h_oe));
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      $display("[ERR] %s expected %h seen %h", nm, x, g);
      num_errors++;
    end
  endtask
  // Request is held until ready is seen high at a rising edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    // Only the bench's cycle limit ends a wait that never sees ready.
    do begin
      @(posedge mclk_i);
    end while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Read frame; len 0 means a plain incrementing stream.
  task rd(input logic opc, input logic [7:0] op, input logic [23:0] a,
          input logic [7:0] m, input int dum, input int nb, input int len);
    int i;
    logic [23:0] x;
    logic [23:0] w;
    w = 24'(len - 1);
    qrs_host_i.frame(opc, op, a, m, 8, dum, nb);
    for (i = 0; i < nb; i++) begin
      x = len == 0 ? a + 24'(i) : (a & ~w) | ((a + 24'(i)) & w);
      chk("data", {24'h0, mem(x)}, {24'h0, qrs_host_i.rx[i]});
    end
    $display("read %h at %h done", op, a);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    apb(1'b0, `QRS_REG_CTRL, 32'h0);
    chk("ctrl", `QRS_CTRL_RST, r);
    apb(1'b0, `QRS_REG_STAT, 32'h0);
    chk("wrap", 32'h1, {29'h0, r[10:8]});
    apb(1'b1, 12'h0FC, 32'h1);
    chk("slverr", 32'h1, {31'h0, e});
    k = oe_cnt;
    qrs_host_i.frame(1'b1, `QRS_OP_QUAD, 24'h000100, 8'h00, 8, 4, 2);
    chk("refused", k, oe_cnt);
    apb(1'b1, `QRS_REG_CTRL, 32'h1);
    $display("register tests done");
    rd(1'b1, `QRS_OP_QUAD, 24'h0001FA, 8'h00, 4, 10, 0);
    rd(1'b1, `QRS_OP_QUAD, 24'h000340, 8'hA5, 4, 3, 0);
    apb(1'b0, `QRS_REG_STAT, 32'h0);
    chk("mode", 32'hA0, {24'h0, r[7:0]});
    rd(1'b0, 8'h00, 24'h000350, 8'h2F, 4, 3, 0);
    rd(1'b0, 8'h00, 24'h000360, 8'h00, 4, 3, 0);
    rd(1'b1, `QRS_OP_QUAD, 24'h000370, 8'h20, 4, 2, 0);
    apb(1'b0, `QRS_REG_ADDR, 32'h0);
    chk("addr", 32'h00000372, r);
    qrs_host_i.frame(1'b1, `QRS_OP_MRST, 24'h0, 8'h00, 0, 0, 0);
    rd(1'b1, `QRS_OP_QUAD, 24'h000380, 8'h00, 4, 2, 0);
    for (k = 0; k < 4; k++) begin
      qrs_host_i.frame(1'b1, `QRS_OP_WRAP, 24'h0, {1'b0, k[1:0], 5'h00}, 8, 0, 0);
      rd(1'b1, `QRS_OP_QUAD, 24'h001240 + 24'(8 << k) - 24'h2, 8'h00, 4, 4, 8 << k);
    end
    rd(1'b1, `QRS_OP_WORD, 24'h00127E, 8'h00, 2, 4, 64);
    qrs_host_i.frame(1'b1, `QRS_OP_WRAP, 24'h0, 8'h10, 8, 0, 0);
    rd(1'b1, `QRS_OP_QUAD, 24'h00123E, 8'h00, 4, 4, 0);
    rd(1'b1, `QRS_OP_WORD, 24'h000402, 8'h20, 2, 4, 0);
    rd(1'b0, 8'h00, 24'h000410, 8'h00, 2, 2, 0);
    rd(1'b1, `QRS_OP_OCT, 24'h000500, 8'h20, 0, 4, 0);
    rd(1'b0, 8'h00, 24'h000510, 8'h00, 0, 2, 0);
    finish_test;
  end
endmodule
bind qrs_top qrs_properties qrs_properties_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .spi_cs_n_i(spi_cs_n_i), .spi_sclk_i(spi_sclk_i), .data_line_oe_o(data_line_oe_o),
  .mem_addr_o(mem_addr_o));
